//--- logic/mtq_pkg.sv
package mtq_pkg;
  // frame byte positions
  localparam int HDR_LEN       = 6;
  localparam int POS_TID_HI    = 0;
  localparam int POS_TID_LO    = 1;
  localparam int POS_PID_HI    = 2;
  localparam int POS_PID_LO    = 3;
  localparam int POS_LEN_HI    = 4;
  localparam int POS_LEN_LO    = 5;
  localparam int POS_STATION   = 6;
  localparam int POS_FUNC      = 7;
  localparam int POS_REF_HI    = 8;
  localparam int POS_REF_LO    = 9;
  localparam int POS_CNT_HI    = 10;
  localparam int POS_CNT_LO    = 11;
  localparam int QRY_LEN       = 12;
  localparam int RSP_LEN       = 12;

  localparam logic [7:0] STATION_BCAST = 8'h00;
  localparam logic [7:0] STATION_MAX   = 8'hF7;
  localparam logic [7:0] FUNC_INVALID  = 8'h00;
  localparam logic [7:0] FUNC_ERR_BIT  = 8'h80;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  localparam logic [7:0] RSP_RTU_LEN   = 8'h06;
  localparam logic [7:0] ONE_BYTE      = 8'h01;

  // function codes
  localparam logic [7:0] FC_RD_COILS   = 8'h01;
  localparam logic [7:0] FC_RD_DINS    = 8'h02;
  localparam logic [7:0] FC_RD_HOLD    = 8'h03;
  localparam logic [7:0] FC_RD_INREG   = 8'h04;
  localparam logic [7:0] FC_WR_COIL    = 8'h05;
  localparam logic [7:0] FC_WR_REG     = 8'h06;
  localparam logic [7:0] FC_WR_COILS   = 8'h0F;
  localparam logic [7:0] FC_WR_REGS    = 8'h10;

  // analog encodings
  localparam int          AI_ENG_SCALE = 10000000;
  localparam logic [31:0] AI_POS_FS    = 32'h7FFFFFFF;
  localparam logic [31:0] AI_NEG_FS    = 32'h80000000;
  localparam logic [3:0]  AI_RANGE_MAX = 4'h9;
  localparam int          AO_ENG_SCALE = 1000;
  localparam logic [1:0]  AO_UNI_10V   = 2'h1;
  localparam logic [15:0] AO_UNI_MIN   = 16'h0000;
  localparam logic [15:0] AO_UNI_MAX   = 16'hFFFF;
  localparam logic [15:0] AO_BIP_MIN   = 16'h8000;
  localparam logic [15:0] AO_BIP_MAX   = 16'h7FFF;

  typedef enum logic [3:0] {
    MTQ_IDLE = 4'b0001,
    MTQ_RECV = 4'b0010,
    MTQ_EXEC = 4'b0100,
    MTQ_SEND = 4'b1000
  } mtq_state_t;
endpackage

//--- logic/mtq_word_order.sv
`timescale 1ns/1ps
// splits a 32-bit value into four wire bytes: low word first, each word high byte first
module mtq_word_order (
  input  wire logic [31:0] value_in,      // value to send
  input  wire logic [1:0]  idx_in,        // byte index on the wire
  output logic      [7:0]  byte_out       // byte at that index
);
  import mtq_pkg::*;
  always_comb begin
    case (idx_in)
      2'h0:    byte_out = value_in[15:8];
      2'h1:    byte_out = value_in[7:0];
      2'h2:    byte_out = value_in[31:24];
      default: byte_out = value_in[23:16];
    endcase
  end
endmodule // mtq_word_order

//--- logic/mtq_query_handler.sv
`timescale 1ns/1ps
module mtq_query_handler #(
  parameter logic [7:0] STATION_ID = 8'h01   // own station address
) (
  input  wire logic        clock_in,      // 100 MHz clock
  input  wire logic        sys_rst_in,    // async reset, active high
  input  wire logic        rx_valid_in,   // query byte strobe
  input  wire logic [7:0]  rx_data_in,    // query byte
  input  wire logic        rx_last_in,    // last byte of query
  input  wire logic [31:0] ai_value_in,   // analog input sample
  input  wire logic        ai_ovr_pos_in, // input above positive full scale
  input  wire logic        ai_ovr_neg_in, // input below negative full scale
  input  wire logic [15:0] ao_code_in,    // requested analog output code
  input  wire logic [1:0]  ao_type_in,    // analog output type code
  input  wire logic [15:0] coil_state_in, // coil readback
  input  wire logic [15:0] din_state_in,  // discrete inputs
  input  wire logic        tx_ready_in,   // response sink ready
  output logic             tx_valid_out,  // response byte strobe
  output logic      [7:0]  tx_data_out,   // response byte
  output logic             tx_last_out,   // last response byte
  output logic             wr_pulse_out,  // write command strobe
  output logic      [7:0]  wr_func_out,   // write function code
  output logic      [15:0] wr_ref_out,    // write reference number
  output logic      [15:0] wr_val_out,    // write value or count
  output logic      [15:0] ao_code_out,   // clamped analog output code
  output logic             err_pulse_out  // query error strobe
);
  import mtq_pkg::*;

  // refuse a station id that is the broadcast address or above the last legal one
  if (STATION_ID == STATION_BCAST || STATION_ID > STATION_MAX) begin : g_bad_station
    $error("station id out of range");
  end

  mtq_state_t  state_r, state_nxt;
  logic [7:0]  frame_r [QRY_LEN], frame_nxt [QRY_LEN];
  logic [7:0]  cnt_r, cnt_nxt;
  logic [7:0]  rsp_func_r, rsp_func_nxt;
  logic [31:0] rsp_val_r, rsp_val_nxt;
  logic        tx_valid_r, tx_valid_nxt, tx_last_r, tx_last_nxt;
  logic [7:0]  tx_data_r, tx_data_nxt;
  logic        wr_pulse_r, wr_pulse_nxt, err_r, err_nxt;
  logic [7:0]  wr_func_r, wr_func_nxt;
  logic [15:0] wr_ref_r, wr_ref_nxt, wr_val_r, wr_val_nxt;
  logic [15:0] ao_r, ao_nxt;
  logic [7:0]  val_byte;
  logic [7:0]  rsp_byte;
  logic        hdr_bad, rtu_bad, func_ok, is_write;
  logic [31:0] ai_sat;

  function automatic logic func_supported(input logic [7:0] fc);
    case (fc)
      FC_RD_COILS, FC_RD_DINS, FC_RD_HOLD, FC_RD_INREG: return 1'b1;
      FC_WR_COIL, FC_WR_REG, FC_WR_COILS, FC_WR_REGS:   return 1'b1;
      default:                                          return 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] be16(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction

  // analog output code clamped to the span of its type
  function automatic logic [15:0] ao_clamp(input logic [15:0] code, input logic [1:0] typ);
    if (typ <= AO_UNI_10V)
      return code;  // full 0000h..FFFFh span
    else if ($signed(code) > $signed(AO_BIP_MAX))
      return AO_BIP_MAX;
    else if ($signed(code) < $signed(AO_BIP_MIN))
      return AO_BIP_MIN;
    else
      return code;
  endfunction

  mtq_word_order u_order (
    .value_in (rsp_val_r),
    .idx_in   (cnt_r[1:0]),
    .byte_out (val_byte)
  );

  always_comb begin
    // input saturation at full scale
    if (ai_ovr_pos_in)      ai_sat = AI_POS_FS;
    else if (ai_ovr_neg_in) ai_sat = AI_NEG_FS;
    else                    ai_sat = ai_value_in;
    hdr_bad = (frame_r[POS_PID_HI] != ZERO_BYTE) || (frame_r[POS_PID_LO] != ZERO_BYTE)
           || (frame_r[POS_LEN_HI] != ZERO_BYTE);
    rtu_bad = (frame_r[POS_LEN_LO] != cnt_r - 8'(HDR_LEN));
    func_ok = (frame_r[POS_FUNC] != FUNC_INVALID) && func_supported(frame_r[POS_FUNC]);
    is_write = frame_r[POS_FUNC] >= FC_WR_COIL;
    case (cnt_r)
      8'(POS_TID_HI), 8'(POS_TID_LO), 8'(POS_PID_HI), 8'(POS_PID_LO), 8'(POS_LEN_HI):
                         rsp_byte = frame_r[cnt_r[3:0]];
      8'(POS_LEN_LO):    rsp_byte = RSP_RTU_LEN;
      8'(POS_STATION):   rsp_byte = frame_r[POS_STATION];
      8'(POS_FUNC):      rsp_byte = rsp_func_r;
      default:           rsp_byte = val_byte;
    endcase
  end

  always_comb begin
    state_nxt    = state_r;
    frame_nxt    = frame_r;
    cnt_nxt      = cnt_r;
    rsp_func_nxt = rsp_func_r;
    rsp_val_nxt  = rsp_val_r;
    tx_valid_nxt = tx_valid_r;
    tx_data_nxt  = tx_data_r;
    tx_last_nxt  = tx_last_r;
    wr_pulse_nxt = 1'b0;
    err_nxt      = 1'b0;
    wr_func_nxt  = wr_func_r;
    wr_ref_nxt   = wr_ref_r;
    wr_val_nxt   = wr_val_r;
    ao_nxt       = ao_clamp(ao_code_in, ao_type_in);
    case (state_r)
      MTQ_IDLE, MTQ_RECV: begin
        if (rx_valid_in) begin
          if (cnt_r < 8'(QRY_LEN))
            frame_nxt[cnt_r[3:0]] = rx_data_in;
          cnt_nxt   = cnt_r + ONE_BYTE;
          state_nxt = MTQ_RECV;
          if (rx_last_in)
            state_nxt = MTQ_EXEC;
        end
      end
      MTQ_EXEC: begin
        rsp_func_nxt = frame_r[POS_FUNC];
        rsp_val_nxt  = 32'h0;
        cnt_nxt      = 8'h0;
        if (hdr_bad || rtu_bad || cnt_r < 8'(QRY_LEN) || !func_ok) begin
          rsp_func_nxt = frame_r[POS_FUNC] | FUNC_ERR_BIT;
          err_nxt      = 1'b1;
        end else begin
          case (frame_r[POS_FUNC])
            FC_RD_COILS: rsp_val_nxt = {16'h0, coil_state_in};
            FC_RD_DINS:  rsp_val_nxt = {16'h0, din_state_in};
            FC_RD_HOLD:  rsp_val_nxt = {16'h0, ao_r};
            FC_RD_INREG: rsp_val_nxt = ai_sat;
            default:     rsp_val_nxt = {16'h0, be16(frame_r[POS_CNT_HI], frame_r[POS_CNT_LO])};
          endcase
          if (is_write) begin
            wr_pulse_nxt = 1'b1;
            wr_func_nxt  = frame_r[POS_FUNC];
            wr_ref_nxt   = be16(frame_r[POS_REF_HI], frame_r[POS_REF_LO]);
            wr_val_nxt   = be16(frame_r[POS_CNT_HI], frame_r[POS_CNT_LO]);
          end
        end
        // only own station answers; broadcast is acted on silently
        if (frame_r[POS_STATION] == STATION_BCAST)
          state_nxt = MTQ_IDLE;
        else if (frame_r[POS_STATION] != STATION_ID || frame_r[POS_STATION] > STATION_MAX) begin
          state_nxt    = MTQ_IDLE;
          wr_pulse_nxt = 1'b0;
          err_nxt      = 1'b0;
        end else
          state_nxt = MTQ_SEND;
      end
      MTQ_SEND: begin
        if (!tx_valid_r || tx_ready_in) begin
          if (tx_valid_r && tx_last_r) begin
            tx_valid_nxt = 1'b0;
            tx_last_nxt  = 1'b0;
            cnt_nxt      = 8'h0;
            state_nxt    = MTQ_IDLE;
          end else begin
            tx_valid_nxt = 1'b1;
            tx_data_nxt  = rsp_byte;
            tx_last_nxt  = cnt_r == 8'(RSP_LEN - 1);
            cnt_nxt      = cnt_r + ONE_BYTE;
          end
        end
      end
      default: state_nxt = MTQ_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r    <= MTQ_IDLE;
      for (int i = 0; i < QRY_LEN; i++)
        frame_r[i] <= 8'h00;
      cnt_r      <= 8'h00;
      rsp_func_r <= 8'h00;
      rsp_val_r  <= 32'h0;
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
      tx_last_r  <= 1'b0;
      wr_pulse_r <= 1'b0;
      err_r      <= 1'b0;
      wr_func_r  <= 8'h00;
      wr_ref_r   <= 16'h0;
      wr_val_r   <= 16'h0;
      ao_r       <= 16'h0;
    end else begin
      state_r    <= state_nxt;
      frame_r    <= frame_nxt;
      cnt_r      <= cnt_nxt;
      rsp_func_r <= rsp_func_nxt;
      rsp_val_r  <= rsp_val_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_data_r  <= tx_data_nxt;
      tx_last_r  <= tx_last_nxt;
      wr_pulse_r <= wr_pulse_nxt;
      err_r      <= err_nxt;
      wr_func_r  <= wr_func_nxt;
      wr_ref_r   <= wr_ref_nxt;
      wr_val_r   <= wr_val_nxt;
      ao_r       <= ao_nxt;
    end
  end

  assign tx_valid_out  = tx_valid_r;
  assign tx_data_out   = tx_data_r;
  assign tx_last_out   = tx_last_r;
  assign wr_pulse_out  = wr_pulse_r;
  assign wr_func_out   = wr_func_r;
  assign wr_ref_out    = wr_ref_r;
  assign wr_val_out    = wr_val_r;
  assign ao_code_out   = ao_r;
  assign err_pulse_out = err_r;
endmodule // mtq_query_handler

//--- bench/mtq_checker.sv
`timescale 1ns/1ps
module mtq_checker (
  input wire logic        clock_in,      // clock
  input wire logic        sys_rst_in,    // reset
  input wire logic        rx_valid_in,   // query strobe
  input wire logic        rx_last_in,    // query end
  input wire logic        tx_ready_in,   // sink ready
  input wire logic [15:0] ao_code_in,    // ao request
  input wire logic        tx_valid_out,  // rsp strobe
  input wire logic [7:0]  tx_data_out,   // rsp byte
  input wire logic        tx_last_out,   // rsp end
  input wire logic        wr_pulse_out,  // write strobe
  input wire logic        err_pulse_out, // error strobe
  input wire logic [15:0] ao_code_out    // ao code
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  property p_hold; tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out); endproperty
  a_hold: assert property (p_hold) else $error("rsp byte not held");
  property p_last; tx_last_out |-> tx_valid_out; endproperty
  a_last: assert property (p_last) else $error("last without valid");
  property p_end; tx_valid_out && tx_ready_in && tx_last_out |=> !tx_valid_out; endproperty
  a_end: assert property (p_end) else $error("rsp runs past last");
  property p_ans; $rose(tx_valid_out) |-> $past(rx_valid_in && rx_last_in, 3); endproperty
  a_ans: assert property (p_ans) else $error("rsp start late or early");
  property p_wr; wr_pulse_out |-> $past(rx_valid_in && rx_last_in, 2) ##1 !wr_pulse_out; endproperty
  a_wr: assert property (p_wr) else $error("write strobe timing");
  property p_err; err_pulse_out |-> $past(rx_valid_in && rx_last_in, 2) ##1 !err_pulse_out; endproperty
  a_err: assert property (p_err) else $error("error strobe timing");
  property p_ao; !$past(sys_rst_in) |-> ao_code_out == $past(ao_code_in); endproperty
  a_ao: assert property (p_ao) else $error("ao code not passed");
  property p_quiet; (!tx_valid_out && !rx_valid_in) [*4] |=> !tx_last_out; endproperty
  a_quiet: assert property (p_quiet) else $error("last while idle");
  c_done: cover property (tx_valid_out && tx_ready_in && tx_last_out);
  c_write: cover property (wr_pulse_out && !err_pulse_out);
  c_bcast: cover property (wr_pulse_out ##1 !tx_valid_out);
endmodule // mtq_checker

bind mtq_query_handler mtq_checker u_chk (.clock_in, .sys_rst_in, .rx_valid_in, .rx_last_in, .tx_ready_in,
  .ao_code_in, .tx_valid_out, .tx_data_out, .tx_last_out, .wr_pulse_out, .err_pulse_out, .ao_code_out);

//--- bench/mtq_client.sv
`timescale 1ns/1ps
module mtq_client (
  input  wire logic       clock_in,     // clock
  input  wire logic       tx_valid_in,  // rsp strobe
  input  wire logic [7:0] tx_data_in,   // rsp byte
  input  wire logic       tx_last_in,   // rsp end
  output logic            rx_valid_out, // query strobe
  output logic      [7:0] rx_data_out,  // query byte
  output logic            rx_last_out,  // query end
  output logic            tx_ready_out  // sink ready
);
  logic [7:0] rsp [12];
  int         rsp_n = 0;
  int         last_at = -1;
  bit         slow = 0;
  initial {rx_valid_out, rx_data_out, rx_last_out, tx_ready_out} = 11'h001;
  // slow sink toggles ready to stretch each byte
  always @(negedge clock_in) tx_ready_out <= !slow || !tx_ready_out;
  always @(posedge clock_in) begin
    if (tx_valid_in && tx_ready_out && rsp_n < 12) begin
      rsp[rsp_n] <= tx_data_in;
      rsp_n      <= rsp_n + 1;
      if (tx_last_in)
        last_at  <= rsp_n;
    end
  end
  task automatic send(input logic [7:0] q [12]);
    for (int i = 0; i < 12; i++) begin
      @(negedge clock_in);
      rx_valid_out <= 1'b1;
      rx_data_out  <= q[i];
      rx_last_out  <= i == 11;
    end
    @(negedge clock_in);
    rx_valid_out <= 1'b0;
    rx_last_out  <= 1'b0;
    rx_data_out  <= ~rx_data_out; // no stale byte left on the line
  endtask
endmodule // mtq_client

//--- bench/mtq_query_handler_tb.sv
`timescale 1ns/1ps
module mtq_query_handler_tb;
  import mtq_pkg::*;
  localparam logic [7:0] MY_ID = 8'h2A;
  logic        clock_in, sys_rst_in, rx_valid, rx_last, tx_ready, tx_valid, tx_last, wr_pulse, err_pulse;
  logic        ovr_p, ovr_n;
  logic [7:0]  rx_data, tx_data, wr_func, qpid;
  logic [15:0] wr_ref, wr_val, ao_in, ao_out, coils, dins, tid;
  logic [31:0] ai;
  logic [1:0]  ao_type;
  int          num_errors = 0;
  int          checks = 0;
  int          wr_seen, err_seen;
  mtq_query_handler #(.STATION_ID(MY_ID)) dut (.clock_in, .sys_rst_in, .rx_valid_in(rx_valid),
    .rx_data_in(rx_data), .rx_last_in(rx_last), .ai_value_in(ai), .ai_ovr_pos_in(ovr_p), .ai_ovr_neg_in(ovr_n),
    .ao_code_in(ao_in), .ao_type_in(ao_type), .coil_state_in(coils), .din_state_in(dins), .tx_ready_in(tx_ready),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_last_out(tx_last), .wr_pulse_out(wr_pulse),
    .wr_func_out(wr_func), .wr_ref_out(wr_ref), .wr_val_out(wr_val), .ao_code_out(ao_out),
    .err_pulse_out(err_pulse));
  mtq_client cli (.clock_in, .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_last_in(tx_last),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_last_out(rx_last), .tx_ready_out(tx_ready));
  always @(posedge clock_in) begin
    wr_seen  <= wr_seen + (wr_pulse === 1'b1);
    err_seen <= err_seen + (err_pulse === 1'b1);
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic query(input logic [7:0] stn, fc, pid, len, input logic [15:0] rf, cn);
    tid = tid + 16'h0111;
    qpid = pid;
    cli.rsp_n = 0;
    cli.last_at = -1;
    wr_seen = 0;
    err_seen = 0;
    cli.send('{tid[15:8], tid[7:0], 8'h00, pid, 8'h00, len, stn, fc, rf[15:8], rf[7:0], cn[15:8], cn[7:0]});
  endtask
  task automatic answer(input logic [7:0] stn, fc, input logic [31:0] v);
    for (int k = 0; cli.rsp_n < 12; k++) begin
      if (k == 300) begin
        num_errors++;
        close_out();
      end
      @(negedge clock_in);
    end
    check("ids", {cli.rsp[0], cli.rsp[1], cli.rsp[2], cli.rsp[3]}, {tid, 8'h00, qpid});
    check("len", {cli.rsp[4], cli.rsp[5]}, {8'h00, RSP_RTU_LEN});
    check("last", cli.last_at, 64'd11);
    check("head", {cli.rsp[6], cli.rsp[7]}, {stn, fc});
    check("value", {cli.rsp[8], cli.rsp[9], cli.rsp[10], cli.rsp[11]}, {v[15:0], v[31:16]});
  endtask
  task automatic sc_reads();
    logic [7:0]  fcs [4];
    logic [31:0] vs [4];
    fcs = '{FC_RD_COILS, FC_RD_DINS, FC_RD_HOLD, FC_RD_INREG};
    vs = '{{16'h0000, coils}, {16'h0000, dins}, {16'h0000, ao_in}, ai};
    cli.slow = 1;
    foreach (fcs[i]) begin
      query(MY_ID, fcs[i], 8'h00, 8'h06, 16'h0000, 16'h0001);
      answer(MY_ID, fcs[i], vs[i]);
    end
    cli.slow = 0;
  endtask
  task automatic sc_writes();
    logic [7:0]  fcs [4];
    logic [15:0] rf, cn;
    fcs = '{FC_WR_COIL, FC_WR_REG, FC_WR_COILS, FC_WR_REGS};
    foreach (fcs[i]) begin
      rf = 16'h0100 + 16'(i);
      cn = 16'hFF00 - 16'(i);
      query(MY_ID, fcs[i], 8'h00, 8'h06, rf, cn);
      answer(MY_ID, fcs[i], {16'h0000, cn});
      check("wr", {wr_seen[7:0], err_seen[7:0], wr_func, wr_ref, wr_val}, {16'h0100, fcs[i], rf, cn});
    end
  endtask
  task automatic sc_errors();
    logic [7:0] pids [4], lens [4], fcs [4];
    pids = '{8'h00, 8'h01, 8'h00, 8'h00};
    lens = '{8'h06, 8'h06, 8'h07, 8'h06};
    fcs = '{FUNC_INVALID, FC_RD_HOLD, FC_RD_HOLD, 8'h07};
    foreach (fcs[i]) begin
      query(MY_ID, fcs[i], pids[i], lens[i], 16'h0000, 16'h0001);
      answer(MY_ID, fcs[i] | FUNC_ERR_BIT, 32'h0);
      check("err", {wr_seen, err_seen}, 64'h1);
    end
  endtask
  task automatic sc_codes();
    for (int i = 0; i < 2; i++) begin
      ovr_p = i == 0;
      ovr_n = i == 1;
      query(MY_ID, FC_RD_INREG, 8'h00, 8'h06, 16'h0000, 16'h0002);
      answer(MY_ID, FC_RD_INREG, i == 0 ? AI_POS_FS : AI_NEG_FS);
    end
    ovr_n = 0;
    ao_type = AO_UNI_10V;
    ao_in = AO_UNI_MAX;
    repeat (2) @(negedge clock_in);
    check("ao", ao_out, AO_UNI_MAX);
  endtask
  task automatic sc_silent();
    query(STATION_BCAST, FC_WR_REG, 8'h00, 8'h06, 16'h0002, 16'h1234);
    repeat (40) @(negedge clock_in);
    check("bcast", {cli.rsp_n[7:0], wr_seen[7:0], err_seen[7:0]}, 24'h000100);
    query(8'h05, FC_WR_REG, 8'h00, 8'h06, 16'h0002, 16'h1234);
    repeat (40) @(negedge clock_in);
    check("other", {cli.rsp_n[7:0], wr_seen[7:0], err_seen[7:0]}, 24'h0);
  endtask
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    sys_rst_in = 1'b1;
    {ovr_p, ovr_n, tid} = 18'h0;
    coils = 16'hA55A;
    dins = 16'h3C96;
    ao_in = AO_BIP_MIN;
    ao_type = 2'h3;
    ai = 32'h0A0B0C0D;
    repeat (2) @(negedge clock_in);
    sys_rst_in = 1'b0;
    sc_reads();
    sc_writes();
    sc_errors();
    sc_codes();
    sc_silent();
    close_out();
  end
endmodule // mtq_query_handler_tb
